// File: rtl/cdi_fifo.sv
`timescale 1ns/1ps
module cdi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_flush,
	// write side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// read side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire empty = (wp_r == rp_r);
	wire push = i_valid && !full;
	wire pop = i_ready && !empty;
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem_r[rp_r[AW-1:0]];
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (i_ce && i_flush) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (i_ce) begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_ce && push && !i_flush)
			mem_r[wp_r[AW-1:0]] <= i_data;
	end
endmodule

// File: rtl/cdi_pkg.sv
package cdi_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int COLS = 40;
	localparam int CELLS = 80;
	localparam logic [6:0] ROW2_FIRST = 7'h28;
	localparam logic [6:0] ROW1_LAST = 7'h27;
	localparam logic [6:0] ROW2_LAST = 7'h4F;
	localparam logic [7:0] BLANK_CHAR = 8'h20;
	localparam logic [7:0] FIRST_PRINT = 8'h20;
	// ****************************************
	// control codes
	// ****************************************
	localparam logic [7:0] DIMMING_CMD = 8'h04;
	localparam logic [7:0] BACKSPACE_CMD = 8'h08;
	localparam logic [7:0] HTAB_CMD = 8'h09;
	localparam logic [7:0] LINEFEED_CMD = 8'h0A;
	localparam logic [7:0] CRET_CMD = 8'h0D;
	localparam logic [7:0] SET_POSITION_CMD = 8'h10;
	localparam logic [7:0] WRAP_MODE_CMD = 8'h11;
	localparam logic [7:0] SCROLL_MODE_CMD = 8'h12;
	localparam logic [7:0] CURSOR_SHOW_CMD = 8'h13;
	localparam logic [7:0] CURSOR_HIDE_CMD = 8'h14;
	localparam logic [7:0] RESET_CMD = 8'h1F;
	// ****************************************
	// dimming data and output levels
	// ****************************************
	localparam logic [7:0] DIM_100 = 8'hFF;
	localparam logic [7:0] DIM_60 = 8'h60;
	localparam logic [7:0] DIM_40 = 8'h40;
	localparam logic [7:0] DIM_20 = 8'h20;
	localparam logic [1:0] LVL_100 = 2'h3;
	localparam logic [1:0] LVL_60 = 2'h2;
	localparam logic [1:0] LVL_40 = 2'h1;
	localparam logic [1:0] LVL_20 = 2'h0;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_1200 = 1200;
	localparam int SELFTEST_STEP_NS = 500_000_000;
	localparam int SELFTEST_STEP_CYC = SELFTEST_STEP_NS / 10;
	localparam logic [7:0] SELFTEST_FIRST = 8'h41;
	localparam int FIFO_DEPTH = 16;
	// ****************************************
	// interpreter states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DIM = 3'b001,
		ST_POS = 3'b010,
		ST_PDATA = 3'b011,
		ST_SCROLL = 3'b100,
		ST_CLEAR = 3'b101
	} cdi_state_t;
endpackage

// File: rtl/cdi_top.sv
`timescale 1ns/1ps
// What this block does
// - self-test input low runs self-test and ignores all writes on both ports
// - self-test steps whole character set, filling all eighty cells at once
// - parallel byte captured on write strobe rising edge while select low
// - two jumper inputs choose 1200, 2400, 4800 or 9600 baud
// - busy high while a received byte is processed, low when ready
// - printable code shown at cursor, then cursor moves right one digit
// - dimming command takes next byte as brightness FF, 60, 40, 20
// - backspace moves left, wrapping between row starts and row ends
// - wrap mode tab moves right, wrapping row ends to row starts
// - scroll mode tab at last cell scrolls, cursor to row two start
// - wrap mode line feed moves to other row, same column
// - scroll mode line feed in row two scrolls, cursor stays
// - carriage return moves cursor to first digit of its row
// - position command takes position byte then data byte written there
// - code 11 selects wrap mode; writes wrap between row ends
// - code 12 selects scroll mode; write at last cell scrolls up
// - codes 13 and 14 show and hide cursor; movement unchanged
// - reset code clears display, homes cursor, scroll mode, cursor on
// - power-on clears display memory, scroll mode, cursor visible
// - serial busy rises at middle of stop bit
module cdi_top
	import cdi_pkg::*;
#(
	parameter int STEP_CYC = SELFTEST_STEP_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// host pins
	input wire logic i_selftest_n,
	input wire logic i_sel_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_data,
	input wire logic i_rxd,
	input wire logic i_baud_jumper_a_n,
	input wire logic i_baud_jumper_b_n,
	output logic o_busy,
	// display side
	input wire logic [6:0] i_disp_addr,
	output logic [7:0] o_disp_char,
	output logic [6:0] o_cursor_pos,
	output logic o_cursor_on,
	output logic o_wrap_mode,
	output logic [1:0] o_dim_level,
	output logic o_selftest
);
	// ****************************************
	// parallel capture
	// ****************************************
	logic wr_n_d_r;
	wire par_take = !i_sel_n && !wr_n_d_r && i_wr_n && i_selftest_n;
	// ****************************************
	// serial receiver
	// ****************************************
	localparam int DIV9600 = CLK_HZ / BAUD_9600;
	wire [1:0] jsel = {i_baud_jumper_a_n, i_baud_jumper_b_n};
	wire [19:0] bit_cyc = (jsel == 2'b00) ? 20'(CLK_HZ / BAUD_1200) :
		(jsel == 2'b10) ? 20'(CLK_HZ / BAUD_2400) :
		(jsel == 2'b01) ? 20'(CLK_HZ / BAUD_4800) : 20'(DIV9600);
	logic rx_s1_r;
	logic rx_s2_r;
	logic rx_act_r;
	logic [19:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	wire rx_tick = rx_cnt_r == 20'h00000;
	wire rx_stop = rx_act_r && rx_tick && rx_bit_r == 4'h9;
	wire rx_take = rx_stop && rx_s2_r && i_selftest_n;
	// ****************************************
	// fifo and interpreter
	// ****************************************
	logic in_valid;
	logic [7:0] in_data;
	logic fifo_ready;
	logic q_valid;
	logic [7:0] q_data;
	logic q_pop;
	assign in_valid = par_take || rx_take;
	assign in_data = par_take ? i_data : rx_sh_r;
	cdi_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_flush(!i_selftest_n),
		.i_valid(in_valid),
		.i_data(in_data),
		.o_ready(fifo_ready),
		.o_valid(q_valid),
		.o_data(q_data),
		.i_ready(q_pop)
	);
	cdi_state_t st_r;
	cdi_state_t st_nxt;
	logic [7:0] mem_r [CELLS];
	logic [6:0] cur_r;
	logic [6:0] pos_r;
	logic [6:0] idx_r;
	logic [6:0] scroll_cur_r;
	logic wrap_r;
	logic curs_r;
	logic [1:0] dim_r;
	logic busy_r;
	logic [7:0] disp_r;
	logic [31:0] step_r;
	logic [7:0] tchar_r;
	wire in_row2 = cur_r >= ROW2_FIRST;
	wire at_end = cur_r == ROW2_LAST;
	wire [6:0] right_w = at_end ? 7'h00 : 7'(cur_r + 7'h01);
	wire [6:0] left_w = (cur_r == 7'h00) ? ROW2_LAST :
		7'(cur_r - 7'h01);
	wire [6:0] other_w = in_row2 ? 7'(cur_r - ROW2_FIRST) :
		7'(cur_r + ROW2_FIRST);
	wire [6:0] home_w = in_row2 ? ROW2_FIRST : 7'h00;
	wire printable = q_data >= FIRST_PRINT;
	// letters, then digits, then every other code as a symbol
	wire [7:0] tnext_w = (tchar_r == 8'h5A) ? 8'h61 :
		(tchar_r == 8'h7A) ? 8'h30 :
		(tchar_r == 8'h39) ? 8'h20 :
		(tchar_r == 8'h2F) ? 8'h3A :
		(tchar_r == 8'h40) ? 8'h5B :
		(tchar_r == 8'h60) ? 8'h7B :
		(tchar_r == 8'hFF) ? SELFTEST_FIRST : 8'(tchar_r + 8'h01);
	wire proc = q_valid && st_r inside {ST_IDLE, ST_DIM, ST_POS, ST_PDATA};
	assign q_pop = i_ce && proc && i_selftest_n;
	// busy while anything is queued or a multi-cycle op runs
	wire busy_w = q_valid || st_r == ST_SCROLL || st_r == ST_CLEAR
		|| !fifo_ready || rx_stop;
	always_comb begin
		st_nxt = st_r;
		if (st_r == ST_SCROLL || st_r == ST_CLEAR) begin
			if (idx_r == ROW2_LAST)
				st_nxt = ST_IDLE;
		end else if (q_pop) begin
			unique case (st_r)
				ST_IDLE: begin
					if (q_data == DIMMING_CMD)
						st_nxt = ST_DIM;
					else if (q_data == SET_POSITION_CMD)
						st_nxt = ST_POS;
					else if (q_data == RESET_CMD)
						st_nxt = ST_CLEAR;
					else if ((printable || q_data == HTAB_CMD) && !wrap_r
						&& at_end)
						st_nxt = ST_SCROLL;
					else if (q_data == LINEFEED_CMD && !wrap_r && in_row2)
						st_nxt = ST_SCROLL;
				end
				ST_DIM: st_nxt = ST_IDLE;
				ST_POS: st_nxt = (q_data > {1'b0, ROW2_LAST}) ?
					ST_IDLE : ST_PDATA;
				ST_PDATA: st_nxt = ST_IDLE;
				default: st_nxt = ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// sequential state
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_n_d_r <= 1'b1;
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_act_r <= 1'b0;
			rx_cnt_r <= 20'h00000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
		end else if (i_ce) begin
			wr_n_d_r <= i_wr_n;
			rx_s1_r <= i_rxd;
			rx_s2_r <= rx_s1_r;
			if (!rx_act_r) begin
				if (!rx_s2_r) begin
					rx_act_r <= 1'b1;
					rx_cnt_r <= 20'(bit_cyc >> 1);
					rx_bit_r <= 4'h0;
				end
			end else if (rx_tick) begin
				rx_cnt_r <= 20'(bit_cyc - 20'h00001);
				rx_bit_r <= 4'(rx_bit_r + 4'h1);
				if (rx_bit_r == 4'h0 && rx_s2_r)
					rx_act_r <= 1'b0;
				else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8)
					rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
				else if (rx_bit_r == 4'h9)
					rx_act_r <= 1'b0;
			end else begin
				rx_cnt_r <= 20'(rx_cnt_r - 20'h00001);
			end
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= ST_CLEAR;
			idx_r <= 7'h00;
			cur_r <= 7'h00;
			pos_r <= 7'h00;
			scroll_cur_r <= 7'h00;
			wrap_r <= 1'b0;
			curs_r <= 1'b1;
			dim_r <= LVL_100;
			busy_r <= 1'b1;
			step_r <= 32'h00000000;
			tchar_r <= SELFTEST_FIRST;
		end else if (i_ce) begin
			st_r <= st_nxt;
			busy_r <= busy_w;
			if (!i_selftest_n) begin
				if (step_r >= 32'(STEP_CYC - 1)) begin
					step_r <= 32'h00000000;
					tchar_r <= tnext_w;
				end else begin
					step_r <= 32'(step_r + 32'h00000001);
				end
			end
			if (st_r == ST_SCROLL || st_r == ST_CLEAR) begin
				idx_r <= (idx_r == ROW2_LAST) ? 7'h00 : 7'(idx_r + 7'h01);
				if (idx_r == ROW2_LAST && st_r == ST_SCROLL)
					cur_r <= scroll_cur_r;
			end
			if (q_pop) begin
				unique case (st_r)
					ST_IDLE: begin
						idx_r <= 7'h00;
						if (printable) begin
							cur_r <= right_w;
							scroll_cur_r <= ROW2_FIRST;
						end else if (q_data == BACKSPACE_CMD)
							cur_r <= left_w;
						else if (q_data == HTAB_CMD) begin
							cur_r <= right_w;
							scroll_cur_r <= ROW2_FIRST;
						end else if (q_data == LINEFEED_CMD) begin
							if (wrap_r || !in_row2)
								cur_r <= other_w;
							scroll_cur_r <= cur_r;
						end else if (q_data == CRET_CMD)
							cur_r <= home_w;
						else if (q_data == WRAP_MODE_CMD)
							wrap_r <= 1'b1;
						else if (q_data == SCROLL_MODE_CMD)
							wrap_r <= 1'b0;
						else if (q_data == CURSOR_SHOW_CMD)
							curs_r <= 1'b1;
						else if (q_data == CURSOR_HIDE_CMD)
							curs_r <= 1'b0;
						else if (q_data == RESET_CMD) begin
							cur_r <= 7'h00;
							wrap_r <= 1'b0;
							curs_r <= 1'b1;
						end
					end
					ST_DIM: begin
						if (q_data == DIM_100)
							dim_r <= LVL_100;
						else if (q_data == DIM_60)
							dim_r <= LVL_60;
						else if (q_data == DIM_40)
							dim_r <= LVL_40;
						else if (q_data == DIM_20)
							dim_r <= LVL_20;
					end
					ST_POS: pos_r <= q_data[6:0];
					ST_PDATA: cur_r <= (pos_r == ROW2_LAST) ? 7'h00 :
						7'(pos_r + 7'h01);
					default: cur_r <= cur_r;
				endcase
			end
		end
	end
	// ****************************************
	// display memory
	// ****************************************
	// scroll copies row two up one cell per cycle, then blanks row two
	wire wr_print = q_pop && st_r == ST_IDLE && printable;
	wire wr_pos = q_pop && st_r == ST_PDATA;
	wire [6:0] wr_addr = wr_pos ? pos_r : cur_r;
	always_ff @(posedge i_core_clk) begin
		if (i_ce) begin
			if (st_r == ST_CLEAR)
				mem_r[idx_r] <= BLANK_CHAR;
			else if (st_r == ST_SCROLL) begin
				if (idx_r < ROW2_FIRST)
					mem_r[idx_r] <= mem_r[7'(idx_r + ROW2_FIRST)];
				else
					mem_r[idx_r] <= BLANK_CHAR;
			end else if (wr_print || wr_pos)
				mem_r[wr_addr] <= q_data;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			disp_r <= BLANK_CHAR;
		else if (i_ce)
			disp_r <= !i_selftest_n ? tchar_r :
				(i_disp_addr <= ROW2_LAST ? mem_r[i_disp_addr] : BLANK_CHAR);
	end
	assign o_busy = busy_r;
	assign o_disp_char = disp_r;
	assign o_cursor_pos = cur_r;
	assign o_cursor_on = curs_r;
	assign o_wrap_mode = wrap_r;
	assign o_dim_level = dim_r;
	assign o_selftest = !i_selftest_n;
endmodule

// File: sim/cdi_host_model.sv
`timescale 1ns/1ps
module cdi_host_model (
	// clock
	input wire logic i_core_clk,
	// parallel port
	output logic o_sel_n,
	output logic o_wr_n,
	output logic [7:0] o_data
);
	// released lines sit at the pull-up level
	initial begin
		o_sel_n = 1'b1;
		o_wr_n = 1'b1;
		o_data = 8'hFF;
	end
	task automatic put(input logic [7:0] b);
		@(posedge i_core_clk);
		o_sel_n <= 1'b0;
		o_data <= b;
		o_wr_n <= 1'b0;
		@(posedge i_core_clk);
		o_wr_n <= 1'b1;
		@(posedge i_core_clk);
		o_sel_n <= 1'b1;
		o_data <= 8'hFF;
	endtask
endmodule

// File: sim/cdi_top_checker.sv
`timescale 1ns/1ps
module cdi_top_checker
	import cdi_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// host pins
	input wire logic i_selftest_n,
	input wire logic i_sel_n,
	input wire logic i_wr_n,
	input wire logic o_busy,
	// display side
	input wire logic [7:0] o_disp_char,
	input wire logic [6:0] o_cursor_pos,
	input wire logic o_cursor_on,
	input wire logic o_wrap_mode,
	input wire logic [1:0] o_dim_level,
	input wire logic o_selftest
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// generous: sixteen queued scrolls still fit
	int busy_cnt_r;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) busy_cnt_r <= 0;
		else busy_cnt_r <= o_busy ? busy_cnt_r + 1 : 0;
	end
	a_reset_state: assert property ($rose(i_rst_n) |-> o_busy &&
		o_cursor_pos == 7'h00 && o_cursor_on && !o_wrap_mode &&
		o_dim_level == LVL_100 && o_disp_char == BLANK_CHAR)
		else $error("state after reset wrong");
	a_busy_rise: assert property ($rose(i_wr_n) && !i_sel_n &&
		i_selftest_n && i_ce && !o_busy |-> ##[1:2] o_busy)
		else $error("busy did not follow write");
	a_test_flag: assert property ((!i_selftest_n) [*2] |->
		o_selftest && o_disp_char >= FIRST_PRINT)
		else $error("selftest output wrong");
	a_test_hold: assert property ((!i_selftest_n) [*4] |->
		$stable(o_cursor_pos) && $stable(o_wrap_mode) &&
		$stable(o_dim_level)) else $error("state moved in selftest");
	a_test_idle: assert property ((!i_selftest_n) [*4] |->
		!$rose(o_busy)) else $error("busy rose in selftest");
	a_cursor_range: assert property (o_cursor_pos <= ROW2_LAST)
		else $error("cursor out of range");
	a_change_busy: assert property ($changed(o_cursor_pos) ||
		$changed(o_wrap_mode) || $changed(o_cursor_on) ||
		$changed(o_dim_level) |-> o_busy || $past(o_busy))
		else $error("state changed while idle");
	a_busy_bound: assert property (busy_cnt_r < 2000)
		else $error("busy held too long");
endmodule
bind cdi_top cdi_top_checker cdi_top_checker_i (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
	.i_selftest_n(i_selftest_n), .i_sel_n(i_sel_n), .i_wr_n(i_wr_n),
	.o_busy(o_busy), .o_disp_char(o_disp_char),
	.o_cursor_pos(o_cursor_pos), .o_cursor_on(o_cursor_on),
	.o_wrap_mode(o_wrap_mode), .o_dim_level(o_dim_level),
	.o_selftest(o_selftest)
);

// File: sim/tb_cdi_top.sv
`timescale 1ns/1ps
module tb_cdi_top;
	import cdi_pkg::*;
	logic i_core_clk, i_rst_n, i_selftest_n, sel_n, wr_n, busy_d, ce, rxd;
	logic o_busy, o_cursor_on, o_wrap_mode, o_selftest;
	logic [7:0] o_disp_char, data;
	logic [6:0] o_cursor_pos, i_disp_addr;
	logic [1:0] o_dim_level;
	logic [15:0] lfsr;
	logic [7:0] shm [80];
	logic [7:0] dims [4] = '{DIM_20, DIM_40, DIM_60, DIM_100};
	logic [10:0] notes [$];
	int errors, comparisons, cur, wm, con, dm, pend, pos;
	wire [10:0] seen = {o_cursor_pos, o_cursor_on, o_wrap_mode, o_dim_level};
	cdi_host_model cdi_host_model_i (.i_core_clk(i_core_clk),
		.o_sel_n(sel_n), .o_wr_n(wr_n), .o_data(data));
	// a whole serial frame would outlast the run: only a false start
	cdi_top #(.STEP_CYC(4)) cdi_top_i (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_selftest_n(i_selftest_n), .i_sel_n(sel_n), .i_wr_n(wr_n),
		.i_data(data), .i_rxd(rxd), .i_baud_jumper_a_n(1'b1),
		.i_baud_jumper_b_n(1'b1), .o_busy(o_busy),
		.i_disp_addr(i_disp_addr), .o_disp_char(o_disp_char),
		.o_cursor_pos(o_cursor_pos), .o_cursor_on(o_cursor_on),
		.o_wrap_mode(o_wrap_mode), .o_dim_level(o_dim_level),
		.o_selftest(o_selftest));
	// ****************************************
	// reference model
	// ****************************************
	function automatic logic [10:0] pack();
		return {cur[6:0], con[0], wm[0], dm[1:0]};
	endfunction
	function automatic void scroll();
		for (int k = 0; k < 40; k++) begin
			shm[k] = shm[k + 40];
			shm[k + 40] = BLANK_CHAR;
		end
	endfunction
	function automatic void adv();
		if (cur < 79) cur++;
		else if (wm) cur = 0;
		else begin
			scroll();
			cur = 40;
		end
	endfunction
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic void step(input logic [7:0] b);
		if (pend == 1) begin
			if (b == DIM_100) dm = 3;
			else if (b == DIM_60) dm = 2;
			else if (b == DIM_40) dm = 1;
			else if (b == DIM_20) dm = 0;
			pend = 0;
		end else if (pend == 2) begin
			pos = b;
			pend = b <= ROW2_LAST ? 3 : 0;
		end else if (pend == 3) begin
			shm[pos] = b;
			cur = pos == 79 ? 0 : pos + 1;
			pend = 0;
		end else case (b)
			DIMMING_CMD: pend = 1;
			SET_POSITION_CMD: pend = 2;
			BACKSPACE_CMD: cur = cur == 0 ? 79 : cur - 1;
			HTAB_CMD: adv();
			LINEFEED_CMD: begin
				if (cur < 40) cur += 40;
				else if (wm) cur -= 40;
				else scroll();
			end
			CRET_CMD: cur = cur < 40 ? 0 : 40;
			WRAP_MODE_CMD: wm = 1;
			SCROLL_MODE_CMD: wm = 0;
			CURSOR_SHOW_CMD: con = 1;
			CURSOR_HIDE_CMD: con = 0;
			RESET_CMD: begin
				foreach (shm[k]) shm[k] = BLANK_CHAR;
				cur = 0;
				wm = 0;
				con = 1;
			end
			default: if (b >= FIRST_PRINT) begin
				shm[cur] = b;
				adv();
			end
		endcase
	endfunction
	// ****************************************
	// checking and driving
	// ****************************************
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_busy(input logic lvl, input int lim);
		for (int k = 0; k < lim; k++) begin
			@(posedge i_core_clk);
			#1;
			if (o_busy === lvl) return;
		end
		errors++;
		$display("wrong value at %0t: busy stuck", $time);
		test_done();
	endtask
	task automatic wr(input logic [7:0] b);
		wait_busy(1'b0, 2000);
		cdi_host_model_i.put(b);
		step(b);
		notes.push_back(pack());
		wait_busy(1'b1, 4);
		wait_busy(1'b0, 400);
	endtask
	task automatic peek(input int a);
		@(posedge i_core_clk);
		i_disp_addr <= a[6:0];
		@(posedge i_core_clk);
		@(posedge i_core_clk);
		#1;
		check({3'h0, o_disp_char}, {3'h0, shm[a]});
	endtask
	always @(negedge i_core_clk) begin
		if (busy_d && !o_busy && notes.size() > 0)
			check(seen, notes.pop_front());
		busy_d = o_busy;
	end
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	initial begin
		errors = 0;
		comparisons = 0;
		pend = 0;
		cur = 0;
		wm = 0;
		con = 1;
		dm = 3;
		lfsr = 16'h06D3;
		ce = 1'b1;
		rxd = 1'b1;
		foreach (shm[k]) shm[k] = BLANK_CHAR;
		i_rst_n = 1'b0;
		i_selftest_n = 1'b1;
		i_disp_addr = 7'h00;
		busy_d = 1'b1;
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		wait_busy(1'b0, 300);
		check(seen, pack());
		peek(79);
		wr(8'h41);
		wr(8'h42);
		peek(1);
		foreach (dims[k]) begin
			wr(DIMMING_CMD);
			wr(dims[k]);
		end
		wr(SET_POSITION_CMD);
		wr(8'h27);
		wr(8'h5A);
		peek(39);
		wr(BACKSPACE_CMD);
		wr(CRET_CMD);
		wr(BACKSPACE_CMD);
		wr(WRAP_MODE_CMD);
		wr(HTAB_CMD);
		wr(LINEFEED_CMD);
		wr(LINEFEED_CMD);
		for (int k = 0; k < 41; k++) wr(8'h61);
		peek(0);
		wr(SCROLL_MODE_CMD);
		wr(SET_POSITION_CMD);
		wr(8'h4E);
		wr(8'h50);
		wr(8'h51);
		peek(39);
		peek(79);
		wr(LINEFEED_CMD);
		wr(SET_POSITION_CMD);
		wr(8'h4E);
		wr(8'h52);
		wr(HTAB_CMD);
		peek(39);
		wr(CURSOR_HIDE_CMD);
		wr(8'h43);
		wr(CURSOR_SHOW_CMD);
		wr(8'h01);
		wr(SET_POSITION_CMD);
		wr(8'h50);
		wr(8'h02);
		repeat (20) begin
			lfsr = lfsr_next(lfsr);
			wr(8'h20 + lfsr[7:0] % 8'h5F);
		end
		peek(cur - 1);
		wr(RESET_CMD);
		peek(41);
		// a write while the clock enable is low must leave no trace
		@(posedge i_core_clk);
		ce <= 1'b0;
		cdi_host_model_i.put(8'h45);
		repeat (4) @(posedge i_core_clk);
		#1;
		check(seen, pack());
		check({10'h000, o_busy}, 11'h000);
		@(posedge i_core_clk);
		ce <= 1'b1;
		peek(0);
		// short low pulse on the serial line is a false start
		@(posedge i_core_clk);
		rxd <= 1'b0;
		repeat (100) @(posedge i_core_clk);
		rxd <= 1'b1;
		repeat (5400) @(posedge i_core_clk);
		#1;
		check(seen, pack());
		check({10'h000, o_busy}, 11'h000);
		@(posedge i_core_clk);
		i_selftest_n <= 1'b0;
		cdi_host_model_i.put(8'h41);
		repeat (10) @(posedge i_core_clk);
		#1;
		check({o_selftest, o_busy, 9'h000}, 11'h400);
		check(seen, pack());
		// four letters shown so far, one per step of four cycles
		check({3'h0, o_disp_char}, {3'h0, SELFTEST_FIRST + 8'h03});
		@(posedge i_core_clk);
		i_selftest_n <= 1'b1;
		wait_busy(1'b0, 400);
		peek(0);
		test_done();
	end
endmodule
